/* verilog/lse_pkg.sv */
package lse_pkg;

  // ---------------------------------------------------------------
  // Register addresses on the management bus.
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_LANE_CFG  = 5'h06; // Lane select register.
  localparam logic [4:0] REG_HS_TP_CFG = 5'h0B; // Fast pattern config.
  localparam logic [4:0] REG_LS_TP_CFG = 5'h0C; // Slow pattern config.
  localparam logic [4:0] REG_CHAN_STAT = 5'h0F; // channel_status_word.
  localparam logic [4:0] REG_HS_CNT    = 5'h10; // fast_side_error_tally.
  localparam logic [4:0] REG_LS_CNT    = 5'h11; // slow_lane_error_tally.
  localparam logic [4:0] REG_LS_STAT   = 5'h13; // slow_lane_status_word.

  // ---------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------
  localparam int         LANE_SEL_LSB = 12;       // Lane select 14:12.
  localparam int         PAT_SEL_LSB  = 8;        // Pattern select 10:8.
  localparam logic [15:0] CNT_RESET   = 16'hFFFD; // Tally reset value.
  localparam logic [15:0] CNT_MAX     = 16'hFFFF; // Tally saturates here.
  localparam logic [15:0] CFG_RESET   = 16'h0000; // Config reset value.

  // ---------------------------------------------------------------
  // Management frame constants.
  // ---------------------------------------------------------------
  localparam logic [5:0] PRE_LEN   = 6'h20; // Preamble ones needed.
  localparam logic [1:0] OP_READ   = 2'h2;  // Read opcode.
  localparam logic [1:0] OP_WRITE  = 2'h1;  // Write opcode.
  localparam logic [3:0] HDR_LAST  = 4'hC;  // Header bits after start.
  localparam logic [3:0] DATA_LAST = 4'hF;  // Data bits minus one.

  typedef enum logic [2:0] {
    ST_PRE,
    ST_HDR,
    ST_TA,
    ST_RDAT,
    ST_WDAT
  } lse_mgmt_state_t;

endpackage

/* verilog/lse_status_regs.sv */
// Overview of operation
// - Channel status bit 0 shows fast synth lock, latched low.
// - Functional mode: fast tally counts bad code words.
// - Fast pattern mode: fast tally counts errors of the selected pattern.
// - Pattern pin high: fast tally counts pseudo-random pattern errors.
// - Fast tally resets to FFFD; a read returns it, then clears it.
// - Slow tally reports the lane chosen by register 6 bits 14:12.
// - Functional mode: slow tally counts the selected lane's bad words.
// - Slow pattern mode counts pattern errors; resets FFFD, clears on read.
// - Slow status bit 15 is live pattern alignment, never latched.
// - Bit 14 shows live loss pattern detect; bit 9 latches it high.
// - Bit 11 latches high on a selected lane invalid code word.
// - Bit 10 latches high on selected lane loss of signal.
// - Bit 8 shows selected lane channel sync, latched low.
// - Bits 3 and 2 latch send FIFO underflow and overflow.
// - Bits 1 and 0 latch receive FIFO underflow and overflow.
// - Status shows one lane; software sets lane select before reading.
// - Functional mode fast invalid decode events feed the fast tally.
module lse_status_regs
  import lse_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR  = 5'h00, // Bus address, arbitrary.
  parameter int         NUM_LANES = 8      // Slow side lanes.
) (
  input  wire logic                 mclk_i,          // System clock.
  input  wire logic                 rst_n_i,         // Async reset, low.
  input  wire logic                 mdc_i,           // Management clock.
  input  wire logic                 mdio_i,          // Management data in.
  output wire logic                 mdio_o,          // Management data out.
  output wire logic                 mdio_oe_o,       // High while driving.
  input  wire logic                 fast_synth_locked_i, // Synth lock.
  input  wire logic                 fast_bad_codeword_i, // Decode invalid.
  input  wire logic                 fast_pattern_err_i,  // Checker error.
  input  wire logic                 fast_tp_verify_i,    // Pattern mode.
  input  wire logic                 pseudo_random_pattern_pin_i, // Pin.
  input  wire logic                 slow_tp_verify_i,    // Pattern mode.
  input  wire logic [NUM_LANES-1:0] slow_bad_codeword_i,    // Per lane.
  input  wire logic [NUM_LANES-1:0] slow_pattern_err_i,     // Per lane.
  input  wire logic [NUM_LANES-1:0] slow_pattern_aligned_i, // Per lane.
  input  wire logic [NUM_LANES-1:0] slow_los_pattern_live_i, // Per lane.
  input  wire logic [NUM_LANES-1:0] slow_signal_lost_i,     // Per lane.
  input  wire logic [NUM_LANES-1:0] slow_channel_synced_i,  // Per lane.
  input  wire logic [NUM_LANES-1:0] slow_send_fifo_empty_err_i, // Pulse.
  input  wire logic [NUM_LANES-1:0] slow_send_fifo_full_err_i,  // Pulse.
  input  wire logic [NUM_LANES-1:0] slow_recv_fifo_empty_err_i, // Pulse.
  input  wire logic [NUM_LANES-1:0] slow_recv_fifo_full_err_i,  // Pulse.
  output wire logic [2:0]           lane_select_field_o, // Reg 6 14:12.
  output wire logic [2:0]           fast_pattern_sel_o,  // Reg 11 10:8.
  output wire logic [2:0]           slow_pattern_sel_o   // Reg 12 10:8.
);

  // ---------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------
  lse_mgmt_state_t state_q;
  logic            mdc_q;
  logic            mdc_rise;
  logic [5:0]      pre_cnt_q;
  logic [3:0]      bit_cnt_q;
  logic [11:0]     hdr_q;
  logic [12:0]     hdr_full;
  logic [15:0]     wsh_q;
  logic [15:0]     shadow_q;
  logic [15:0]     rd_mux;
  logic            mdio_q;
  logic            mdio_oe_q;
  logic            rd_take;
  logic            wr_take;
  logic            fast_clr;
  logic            slow_cnt_clr;
  logic            slow_stat_clr;
  logic            chan_clr;
  logic [15:0]     cfg_lane_q;
  logic [15:0]     cfg_fast_q;
  logic [15:0]     cfg_slow_q;
  logic [2:0]      lane_sel;
  logic            lock_drop_q;
  logic [15:0]     chan_word;
  logic [15:0]     fast_cnt_q;
  logic            fast_event;
  logic [15:0]     slow_cnt_q [NUM_LANES];
  logic [6:0]      sticky_q   [NUM_LANES];
  logic            sync_drop_q [NUM_LANES];
  logic [15:0]     slow_word;

  // Header decode: start bit, opcode and address match.
  function automatic logic hdr_is(input logic [12:0] h,
                                  input logic [1:0]  op);
    hdr_is = h[12] && (h[11:10] == op) && (h[9:5] == PHY_ADDR);
  endfunction

  // ---------------------------------------------------------------
  // Management bus slave.
  // ---------------------------------------------------------------
  // The management clock is sampled as a plain synchronous input, so
  // it must run well below half of the system clock.
  assign mdc_rise  = mdc_i & ~mdc_q;
  assign hdr_full  = {hdr_q, mdio_i};
  assign rd_take   = mdc_rise && (state_q == ST_HDR) && (bit_cnt_q == 4'h0)
                     && hdr_is(hdr_full, OP_READ);
  // After the header the start bit has left hdr_q, so a one stands in
  // for it; the stored opcode, address and register stay aligned.
  assign wr_take   = mdc_rise && (state_q == ST_WDAT) && (bit_cnt_q == 4'h0)
                     && hdr_is({1'b1, hdr_q}, OP_WRITE);
  assign mdio_o    = mdio_q;
  assign mdio_oe_o = mdio_oe_q;

  // Frame sequencer; data changes just after each management rising edge.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdc_q     <= 1'b0;
      state_q   <= ST_PRE;
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 4'h0;
      hdr_q     <= 12'h000;
      wsh_q     <= 16'h0000;
      mdio_q    <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      mdc_q <= mdc_i;
      if (mdc_rise) begin
        unique case (state_q)
          ST_PRE: begin
            if (mdio_i) begin
              if (pre_cnt_q != PRE_LEN) begin
                pre_cnt_q <= pre_cnt_q + 6'h01;
              end
            end else begin
              if (pre_cnt_q == PRE_LEN) begin
                state_q   <= ST_HDR;
                bit_cnt_q <= HDR_LAST;
              end
              pre_cnt_q <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr_q     <= hdr_full[11:0];
            bit_cnt_q <= bit_cnt_q - 4'h1;
            if (bit_cnt_q == 4'h0) begin
              state_q   <= ST_TA;
              bit_cnt_q <= 4'h1;
            end
          end
          ST_TA: begin
            if (bit_cnt_q == 4'h1) begin
              bit_cnt_q <= 4'h0;
              mdio_oe_q <= hdr_is({1'b1, hdr_q}, OP_READ);
              mdio_q    <= 1'b0;
            end else if (mdio_oe_q) begin
              state_q   <= ST_RDAT;
              mdio_q    <= shadow_q[15];
              bit_cnt_q <= DATA_LAST;
            end else begin
              state_q   <= ST_WDAT;
              bit_cnt_q <= DATA_LAST;
            end
          end
          ST_RDAT: begin
            if (bit_cnt_q == 4'h0) begin
              state_q   <= ST_PRE;
              mdio_oe_q <= 1'b0;
            end else begin
              mdio_q    <= shadow_q[bit_cnt_q - 4'h1];
              bit_cnt_q <= bit_cnt_q - 4'h1;
            end
          end
          ST_WDAT: begin
            wsh_q     <= {wsh_q[14:0], mdio_i};
            bit_cnt_q <= bit_cnt_q - 4'h1;
            if (bit_cnt_q == 4'h0) begin
              state_q <= ST_PRE;
            end
          end
        endcase
      end
    end
  end

  // Read data is frozen when the address is known, which is also the
  // moment clear-on-read takes effect, so the value returned and the
  // value cleared are the same one.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shadow_q <= 16'h0000;
    end else if (rd_take) begin
      shadow_q <= rd_mux;
    end
  end

  // Configuration registers written over the management bus.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_lane_q <= CFG_RESET;
      cfg_fast_q <= CFG_RESET;
      cfg_slow_q <= CFG_RESET;
    end else if (wr_take) begin
      if (hdr_q[4:0] == REG_LANE_CFG) begin
        cfg_lane_q <= {wsh_q[14:0], mdio_i};
      end
      if (hdr_q[4:0] == REG_HS_TP_CFG) begin
        cfg_fast_q <= {wsh_q[14:0], mdio_i};
      end
      if (hdr_q[4:0] == REG_LS_TP_CFG) begin
        cfg_slow_q <= {wsh_q[14:0], mdio_i};
      end
    end
  end

  assign lane_sel            = cfg_lane_q[LANE_SEL_LSB+:3];
  assign lane_select_field_o = lane_sel;
  assign fast_pattern_sel_o  = cfg_fast_q[PAT_SEL_LSB+:3];
  assign slow_pattern_sel_o  = cfg_slow_q[PAT_SEL_LSB+:3];

  // Read-side decode and clear strobes.
  assign fast_clr      = rd_take && (hdr_full[4:0] == REG_HS_CNT);
  assign slow_cnt_clr  = rd_take && (hdr_full[4:0] == REG_LS_CNT);
  assign slow_stat_clr = rd_take && (hdr_full[4:0] == REG_LS_STAT);
  assign chan_clr      = rd_take && (hdr_full[4:0] == REG_CHAN_STAT);

  always_comb begin
    unique case (hdr_full[4:0])
      REG_LANE_CFG:  rd_mux = cfg_lane_q;
      REG_HS_TP_CFG: rd_mux = cfg_fast_q;
      REG_LS_TP_CFG: rd_mux = cfg_slow_q;
      REG_CHAN_STAT: rd_mux = chan_word;
      REG_HS_CNT:    rd_mux = fast_cnt_q;
      REG_LS_CNT:    rd_mux = slow_cnt_q[lane_sel];
      REG_LS_STAT:   rd_mux = slow_word;
      default:       rd_mux = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Channel status and fast side tally.
  // ---------------------------------------------------------------
  // A drop in lock is remembered until read; a drop in the read cycle
  // itself is kept.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_drop_q <= 1'b0;
    end else begin
      lock_drop_q <= ~fast_synth_locked_i
                     | (lock_drop_q & ~chan_clr);
    end
  end
  assign chan_word = {15'h0000, fast_synth_locked_i & ~lock_drop_q};

  // Pattern modes take the checker's errors; otherwise decode errors.
  assign fast_event = (pseudo_random_pattern_pin_i | fast_tp_verify_i) ?
                      fast_pattern_err_i :
                      fast_bad_codeword_i;

  // The tally saturates rather than wraps, so a reading never hides
  // a burst. An error in the clearing cycle counts as the first one.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fast_cnt_q <= CNT_RESET;
    end else if (fast_clr) begin
      fast_cnt_q <= {15'h0000, fast_event};
    end else if (fast_event && fast_cnt_q != CNT_MAX) begin
      fast_cnt_q <= fast_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Slow side per-lane tallies and flags.
  // ---------------------------------------------------------------
  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    logic       ev;
    logic       sel;
    logic [6:0] src;
    assign sel = (lane_sel == 3'(l));
    assign ev  = slow_tp_verify_i ? slow_pattern_err_i[l] :
                 slow_bad_codeword_i[l];
    assign src = {slow_bad_codeword_i[l], slow_signal_lost_i[l],
                  slow_los_pattern_live_i[l],
                  slow_send_fifo_empty_err_i[l], slow_send_fifo_full_err_i[l],
                  slow_recv_fifo_empty_err_i[l], slow_recv_fifo_full_err_i[l]};

    // Counter with clear-on-read of the selected lane only.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        slow_cnt_q[l] <= CNT_RESET;
      end else if (slow_cnt_clr && sel) begin
        slow_cnt_q[l] <= {15'h0000, ev};
      end else if (ev && slow_cnt_q[l] != CNT_MAX) begin
        slow_cnt_q[l] <= slow_cnt_q[l] + 16'h0001;
      end
    end

    // Sticky flags: a new event beats the read clear.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sticky_q[l]    <= 7'h00;
        sync_drop_q[l] <= 1'b0;
      end else begin
        sticky_q[l]    <= src | (sticky_q[l] &
                          ~{7{slow_stat_clr & sel}});
        sync_drop_q[l] <= ~slow_channel_synced_i[l] |
                          (sync_drop_q[l] & ~(slow_stat_clr & sel));
      end
    end
  end

  // Selected lane status word.
  assign slow_word = {slow_pattern_aligned_i[lane_sel],
                      slow_los_pattern_live_i[lane_sel],
                      2'b00,
                      sticky_q[lane_sel][6:4],
                      slow_channel_synced_i[lane_sel]
                        & ~sync_drop_q[lane_sel],
                      4'h0,
                      sticky_q[lane_sel][3:0]};

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  sequence s_fast_read;
    fast_clr ##1 1'b1;
  endsequence

  property p_lock_low;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !fast_synth_locked_i ##1 !chan_clr |=> !chan_word[0];
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock drop lost");

  property p_fast_func;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !fast_tp_verify_i && !pseudo_random_pattern_pin_i && fast_bad_codeword_i
      && !fast_clr && fast_cnt_q != CNT_MAX
      |=> fast_cnt_q == $past(fast_cnt_q) + 16'h0001;
  endproperty
  a_fast_func: assert property (p_fast_func) else $error("fast miss");

  property p_fast_tp;
    @(posedge mclk_i) disable iff (!rst_n_i)
      fast_tp_verify_i && !fast_pattern_err_i && !fast_clr
      |=> fast_cnt_q == $past(fast_cnt_q);
  endproperty
  a_fast_tp: assert property (p_fast_tp) else $error("fast tp count");

  property p_fast_pin;
    @(posedge mclk_i) disable iff (!rst_n_i)
      pseudo_random_pattern_pin_i && fast_pattern_err_i && !fast_clr
      && fast_cnt_q != CNT_MAX |=> fast_cnt_q != $past(fast_cnt_q);
  endproperty
  a_fast_pin: assert property (p_fast_pin) else $error("pin miss");

  property p_fast_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_fast_read |-> fast_cnt_q <= 16'h0001;
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("no clear");

  property p_slow_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      slow_cnt_clr |=> slow_cnt_q[$past(lane_sel)] <= 16'h0001;
  endproperty
  a_slow_clear: assert property (p_slow_clear) else $error("slow clr");

  property p_los_sticky;
    @(posedge mclk_i) disable iff (!rst_n_i)
      slow_los_pattern_live_i[lane_sel] |=> sticky_q[$past(lane_sel)][4];
  endproperty
  a_los_sticky: assert property (p_los_sticky) else $error("los lost");

  property p_hold_high;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sticky_q[lane_sel][6] && !slow_stat_clr
      |=> sticky_q[$past(lane_sel)][6];
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("flag fell");

  property p_hold_low;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !slow_channel_synced_i[lane_sel] ##1 !slow_stat_clr
      |=> sync_drop_q[$past(lane_sel, 2)];
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("sync rose");

endmodule

/* testbench/lse_mgmt_station.sv */
module lse_mgmt_station
  import lse_pkg::*;
(
  input  wire logic mclk_i,    // System clock for pacing.
  input  wire logic mdio_i,    // Resolved data line.
  output logic      mdc_o,     // Management clock.
  output logic      mdio_o,    // Station data.
  output logic      mdio_oe_o  // High while the station drives.
);
  timeunit 1ns;
  timeprecision 1ns;

  // The clock stands low and the line is released outside frames.
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // One period of four slow cycles low and four high; sampling just
  // before the rise gives the device a full period to settle its bit.
  task automatic cyc(input logic drv, input logic b, output logic s);
    @(negedge mclk_i);
    mdio_oe_o = drv;
    mdio_o = b;
    repeat (3) @(negedge mclk_i);
    s = mdio_i;
    mdc_o = 1'b1;
    repeat (4) @(negedge mclk_i);
    mdc_o = 1'b0;
  endtask

  // A whole frame with fresh preamble; reads release the line from
  // the turnaround on, so nothing driven reads back as all ones.
  task automatic frame(input logic [4:0] phy, input logic [1:0] op,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] h;
    logic        s;
    logic        rdop;
    h = {2'b01, op, phy, ra};
    rdop = (op == OP_READ);
    rd = 16'h0000;
    for (int i = 0; i < 32; i++)
      cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      cyc(1'b1, h[i], s);
    cyc(!rdop, 1'b1, s);
    cyc(!rdop, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      cyc(!rdop, wd[i], s);
      rd[i] = s;
    end
    @(negedge mclk_i);
    mdio_oe_o = 1'b0;
  endtask
endmodule

/* testbench/tb.sv */
module tb
  import lse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Stimulus signals.
  // ---------------------------------------------------------------
  logic       mclk = 1'b0, rst_n = 1'b0, mdc, mdio_w, dut_do, dut_oe;
  logic       st_do, st_oe, fast_lock = 1'b1, fast_bad = 1'b0;
  logic       fast_perr = 1'b0, fast_tp = 1'b0, prbs = 1'b0;
  logic       slow_tp = 1'b0;
  logic [7:0] sbad = '0, sperr = '0, salign = '0, slos = '0, slost = '0;
  logic [7:0] ssync = 8'hFF, sfe = '0, sff = '0, rfe = '0, rff = '0;
  logic [2:0] lane_sel, fast_sel, slow_sel;
  int         err_total = 0;
  int         n_checks = 0;

  // Half period of 20 ns gives the 25 MHz system clock.
  always #20 mclk = ~mclk;

  // The data line has a pull-up, so a released line reads high.
  assign mdio_w = dut_oe ? dut_do : (st_oe ? st_do : 1'b1);

  lse_status_regs DUT (
    .mclk_i(mclk), .rst_n_i(rst_n), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(dut_do), .mdio_oe_o(dut_oe),
    .fast_synth_locked_i(fast_lock), .fast_bad_codeword_i(fast_bad),
    .fast_pattern_err_i(fast_perr), .fast_tp_verify_i(fast_tp),
    .pseudo_random_pattern_pin_i(prbs), .slow_tp_verify_i(slow_tp),
    .slow_bad_codeword_i(sbad), .slow_pattern_err_i(sperr),
    .slow_pattern_aligned_i(salign), .slow_los_pattern_live_i(slos),
    .slow_signal_lost_i(slost), .slow_channel_synced_i(ssync),
    .slow_send_fifo_empty_err_i(sfe), .slow_send_fifo_full_err_i(sff),
    .slow_recv_fifo_empty_err_i(rfe), .slow_recv_fifo_full_err_i(rff),
    .lane_select_field_o(lane_sel), .fast_pattern_sel_o(fast_sel),
    .slow_pattern_sel_o(slow_sel));

  lse_mgmt_station stn (
    .mclk_i(mclk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(st_do),
    .mdio_oe_o(st_oe));

  // ---------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    stn.frame(5'h00, OP_READ, a, 16'h0000, d);
    chk(d, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [15:0] d;
    stn.frame(5'h00, OP_WRITE, a, v, d);
  endtask

  task automatic pulse(input int n, ref logic s);
    repeat (n) begin
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
    end
  endtask

  task automatic vpulse(input int n, input int ln, ref logic [7:0] v);
    repeat (n) begin
      @(negedge mclk);
      v[ln] = 1'b1;
      @(negedge mclk);
      v[ln] = 1'b0;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------
  task automatic t_reset;
    rchk(REG_HS_CNT, CNT_RESET);
    rchk(REG_HS_CNT, 16'h0000);
    rchk(REG_LS_CNT, CNT_RESET);
    rchk(REG_CHAN_STAT, 16'h0001);
    rchk(REG_LANE_CFG, CFG_RESET);
    rchk(5'h12, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_fast;
    pulse(3, fast_bad);
    pulse(2, fast_perr);
    rchk(REG_HS_CNT, 16'h0003);
    wr(REG_HS_TP_CFG, 16'h0500);
    chk({13'h0, fast_sel}, 16'h0005);
    fast_tp = 1'b1;
    pulse(4, fast_perr);
    pulse(1, fast_bad);
    rchk(REG_HS_CNT, 16'h0004);
    fast_tp = 1'b0;
    prbs = 1'b1;
    pulse(2, fast_perr);
    rchk(REG_HS_CNT, 16'h0002);
    prbs = 1'b0;
    $display("test fast tally done");
  endtask

  // Lane 5 starts at the reset value, so its first two of three errors reach saturation.
  task automatic t_lane;
    wr(REG_LANE_CFG, 16'h5000);
    chk({13'h0, lane_sel}, 16'h0005);
    vpulse(3, 5, sbad);
    vpulse(1, 2, sbad);
    rchk(REG_LS_CNT, CNT_MAX);
    rchk(REG_LS_CNT, 16'h0000);
    wr(REG_LS_TP_CFG, 16'h0300);
    chk({13'h0, slow_sel}, 16'h0003);
    slow_tp = 1'b1;
    vpulse(2, 5, sperr);
    vpulse(1, 5, sbad);
    rchk(REG_LS_CNT, 16'h0002);
    slow_tp = 1'b0;
    wr(REG_LANE_CFG, 16'h2000);
    rchk(REG_LS_CNT, 16'hFFFE);
    $display("test slow tally done");
  endtask

  // Lane 5 still holds its decode flag from the tally test.
  task automatic t_status;
    wr(REG_LANE_CFG, 16'h5000);
    rchk(REG_LS_STAT, 16'h0900);
    salign[5] = 1'b1;
    vpulse(1, 5, slos);
    vpulse(1, 5, slost);
    vpulse(1, 5, sbad);
    vpulse(1, 5, sfe);
    vpulse(1, 5, sff);
    vpulse(1, 5, rfe);
    vpulse(1, 5, rff);
    vpulse(1, 3, sff);
    @(negedge mclk);
    ssync[5] = 1'b0;
    @(negedge mclk);
    ssync[5] = 1'b1;
    rchk(REG_LS_STAT, 16'h8E0F);
    rchk(REG_LS_STAT, 16'h8100);
    slos[5] = 1'b1;
    rchk(REG_LS_STAT, 16'hC300);
    slos[5] = 1'b0;
    salign[5] = 1'b0;
    $display("test slow status done");
  endtask

  task automatic t_lock;
    fast_lock = 1'b0;
    repeat (2) @(negedge mclk);
    fast_lock = 1'b1;
    rchk(REG_CHAN_STAT, 16'h0000);
    rchk(REG_CHAN_STAT, 16'h0001);
    $display("test lock done");
  endtask

  // Frames for another address must neither answer, write nor clear.
  task automatic t_refuse;
    logic [15:0] d;
    pulse(1, fast_bad);
    stn.frame(5'h01, OP_READ, REG_HS_CNT, 16'h0000, d);
    chk(d, 16'hFFFF);
    stn.frame(5'h01, OP_WRITE, REG_LANE_CFG, 16'h7000, d);
    chk({13'h0, lane_sel}, 16'h0005);
    rchk(REG_HS_CNT, 16'h0001);
    $display("test refused frames done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset for four cycles, then the scenarios in order.
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_fast();
    t_lane();
    t_status();
    t_lock();
    t_refuse();
    wrap_up();
  end

  // About thirty frames of some 513 cycles each need well under 1 ms.
  initial begin
    #3000000;
    err_total++;
    wrap_up();
  end
endmodule
